//--- vbi_data_slicer.sv
`timescale 1ns/1ps
module vbi_data_slicer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  video_a,
  input  wire logic [7:0]  video_b,
  input  wire logic        horizontal_reference,
  input  wire logic        vertical_reference,
  input  wire logic        field_id,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  output logic      [7:0]  reg_rdata,
  output logic      [31:0] out_data,
  output logic             out_last,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic             line_ready
);

  localparam int NL = vbi_slicer_pkg::NUM_LINES;
  localparam int SW = vbi_slicer_pkg::SECT_WORDS;

  logic [7:0]  ctrl_r;
  logic [7:0]  line_sel_r [NL];
  logic [7:0]  horiz_trigger_offset_lo_r;
  logic [7:0]  vert_trigger_offset_lo_r;
  logic [7:0]  off_hi_r;
  logic [7:0]  fc_prog_r;
  logic [7:0]  type_r;
  logic [7:0]  reg_rdata_r;
  logic [7:0]  rd_nxt;
  logic [4:0]  rd_idx;

  logic [10:0] horiz_trigger_offset;
  logic [8:0]  vert_trigger_offset;
  logic        field_offset_bit;

  // Register writes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r    <= vbi_slicer_pkg::RST_CTRL;
      horiz_trigger_offset_lo_r <= vbi_slicer_pkg::RST_OFF;
      vert_trigger_offset_lo_r <= vbi_slicer_pkg::RST_OFF;
      off_hi_r  <= vbi_slicer_pkg::RST_OFF;
      fc_prog_r <= vbi_slicer_pkg::RST_FC;
      type_r    <= vbi_slicer_pkg::RST_TYPE;
    end else if (reg_we) begin
      case (reg_addr)
        vbi_slicer_pkg::ADDR_CTRL:    ctrl_r    <= reg_wdata;
        vbi_slicer_pkg::ADDR_HORIZ_TRIGGER_OFFSET_LO: horiz_trigger_offset_lo_r <= reg_wdata;
        vbi_slicer_pkg::ADDR_VERT_TRIGGER_OFFSET_LO: vert_trigger_offset_lo_r <= reg_wdata;
        vbi_slicer_pkg::ADDR_OFF_HI:  off_hi_r  <= reg_wdata;
        vbi_slicer_pkg::ADDR_FC_PROG: fc_prog_r <= reg_wdata;
        vbi_slicer_pkg::ADDR_TYPE:    type_r    <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Per-line standard selections
  for (genvar i = 0; i < NL; i++) begin : g_line
    always_ff @(posedge clk) begin
      if (!rstn) begin
        line_sel_r[i] <= vbi_slicer_pkg::RST_LINE;
      end else if (reg_we &&
                   reg_addr == vbi_slicer_pkg::ADDR_LINE_FIRST + 8'(i)) begin
        line_sel_r[i] <= reg_wdata;
      end
    end
  end

  assign rd_idx = 5'(reg_addr - vbi_slicer_pkg::ADDR_LINE_FIRST);

  always_comb begin
    rd_nxt = 8'h00;
    if (reg_addr >= vbi_slicer_pkg::ADDR_LINE_FIRST &&
        reg_addr <= vbi_slicer_pkg::ADDR_LINE_LAST) begin
      rd_nxt = line_sel_r[rd_idx];
    end else begin
      case (reg_addr)
        vbi_slicer_pkg::ADDR_CTRL:    rd_nxt = ctrl_r;
        vbi_slicer_pkg::ADDR_HORIZ_TRIGGER_OFFSET_LO: rd_nxt = horiz_trigger_offset_lo_r;
        vbi_slicer_pkg::ADDR_VERT_TRIGGER_OFFSET_LO: rd_nxt = vert_trigger_offset_lo_r;
        vbi_slicer_pkg::ADDR_OFF_HI:  rd_nxt = off_hi_r;
        vbi_slicer_pkg::ADDR_FC_PROG: rd_nxt = fc_prog_r;
        vbi_slicer_pkg::ADDR_TYPE:    rd_nxt = type_r;
        default:                      rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= rd_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;

  // Offsets assembled from the three registers
  assign horiz_trigger_offset = {off_hi_r[vbi_slicer_pkg::HORIZ_TRIGGER_OFFSET_HI_LSB +: 3],
                                 horiz_trigger_offset_lo_r};
  assign vert_trigger_offset  = {off_hi_r[vbi_slicer_pkg::VERT_TRIGGER_OFFSET_HI_BIT],
                                 vert_trigger_offset_lo_r};
  assign field_offset_bit     = off_hi_r[vbi_slicer_pkg::FIELD_OFFSET_BIT_BIT];

  // Line timing from reference edges
  logic        horizontal_reference_d_r;
  logic        vref_d_r;
  logic        horizontal_reference_fall;
  logic        vref_fall;
  logic [10:0] hcnt_r;
  logic [8:0]  vcnt_r;
  logic [8:0]  line_num;
  logic        line_ok;
  logic        field;

  assign horizontal_reference_fall = horizontal_reference_d_r && !horizontal_reference;
  assign vref_fall = vref_d_r && !vertical_reference;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      horizontal_reference_d_r <= 1'b0;
      vref_d_r <= 1'b0;
      hcnt_r   <= 11'h000;
      vcnt_r   <= 9'h000;
    end else begin
      horizontal_reference_d_r <= horizontal_reference;
      vref_d_r <= vertical_reference;
      if (horizontal_reference_fall) begin
        hcnt_r <= 11'h000;
      end else if (hcnt_r != 11'h7FF) begin
        hcnt_r <= hcnt_r + 11'h001;
      end
      if (vref_fall) begin
        vcnt_r <= 9'h000;
      end else if (horizontal_reference_fall && vcnt_r != 9'h1FF) begin
        vcnt_r <= vcnt_r + 9'h001;
      end
    end
  end

  assign line_ok  = vcnt_r >= vert_trigger_offset;
  assign line_num = vcnt_r - vert_trigger_offset;
  assign field    = field_id ^ field_offset_bit;

  // Standard chosen for the current line
  logic [3:0] line_type;
  logic [7:0] sel;
  logic [4:0] sel_idx;

  always_comb begin
    sel_idx = 5'(line_num - 9'(vbi_slicer_pkg::FIRST_LINE));
    if (line_num > 9'(vbi_slicer_pkg::LAST_LINE)) begin
      sel_idx = 5'(NL - 1);
    end
    sel = line_sel_r[sel_idx];
    line_type = field ? sel[7:4] : sel[3:0];
    if (!line_ok || line_num < 9'(vbi_slicer_pkg::FIRST_LINE)) begin
      line_type = type_r[3:0];
    end
  end

  // Per-type slicing parameters
  logic [31:0] inc_nxt;
  logic [23:0] fc_nxt;
  logic [4:0]  fc_len_nxt;
  logic [5:0]  nbytes_nxt;
  logic        ham_nxt;
  logic        open_nxt;
  logic        en_nxt;

  always_comb begin
    inc_nxt    = vbi_slicer_pkg::INC_5000;
    fc_nxt     = {16'h0000, fc_prog_r};
    fc_len_nxt = 5'd8;
    nbytes_nxt = 6'd2;
    ham_nxt    = 1'b0;
    open_nxt   = 1'b0;
    en_nxt     = 1'b1;
    case (line_type)
      vbi_slicer_pkg::T_WST625, vbi_slicer_pkg::T_WST525: begin
        inc_nxt    = line_type == vbi_slicer_pkg::T_WST625 ?
                     vbi_slicer_pkg::INC_6937 : vbi_slicer_pkg::INC_5727;
        fc_nxt     = vbi_slicer_pkg::FC_TEXT;
        nbytes_nxt = 6'd42;
        ham_nxt    = 1'b1;
      end
      vbi_slicer_pkg::T_CC625, vbi_slicer_pkg::T_CC525: begin
        inc_nxt    = line_type == vbi_slicer_pkg::T_CC625 ?
                     vbi_slicer_pkg::INC_0500 : vbi_slicer_pkg::INC_0503;
        fc_nxt     = vbi_slicer_pkg::FC_CC;
        fc_len_nxt = 5'd3;
      end
      vbi_slicer_pkg::T_VPS: begin
        fc_nxt     = vbi_slicer_pkg::FC_VPS;
        fc_len_nxt = 5'd16;
        nbytes_nxt = 6'd13;
      end
      vbi_slicer_pkg::T_WSS: begin
        fc_nxt     = vbi_slicer_pkg::FC_WSS;
        fc_len_nxt = 5'd24;
      end
      vbi_slicer_pkg::T_TEXT: begin
        inc_nxt    = vbi_slicer_pkg::INC_6937;
        nbytes_nxt = 6'd42;
      end
      vbi_slicer_pkg::T_USTEXT, vbi_slicer_pkg::T_JAPTEXT: begin
        inc_nxt    = vbi_slicer_pkg::INC_5727;
        nbytes_nxt = 6'd36;
      end
      vbi_slicer_pkg::T_VITC625: begin
        inc_nxt    = vbi_slicer_pkg::INC_1812;
        nbytes_nxt = 6'd9;
      end
      vbi_slicer_pkg::T_VITC525: begin
        inc_nxt    = vbi_slicer_pkg::INC_1789;
        nbytes_nxt = 6'd9;
      end
      vbi_slicer_pkg::T_FSWITCH: begin
        open_nxt   = 1'b1;
      end
      default: begin
        en_nxt     = 1'b0;
      end
    endcase
  end

  // Slicer sequence
  vbi_slicer_pkg::slicer_state_type state_r;
  logic [31:0] inc_r;
  logic [31:0] phase_r;
  logic [32:0] phase_sum;
  logic        strobe;
  logic [23:0] fc_r;
  logic [23:0] fc_mask_r;
  logic [5:0]  nbytes_r;
  logic        ham_r;
  logic        open_r;
  logic [7:0]  vmin_r;
  logic [7:0]  vmax_r;
  logic [8:0]  level_sum;
  logic [7:0]  sample;
  logic        bit_now;
  logic        bit_d_r;
  logic [1:0]  edge_cnt_r;
  logic [23:0] sh_r;
  logic [23:0] sh_nxt;
  logic [5:0]  fbits_r;
  logic [2:0]  bitc_r;
  logic [7:0]  byte_r;
  logic [7:0]  byte_nxt;
  logic [5:0]  bytes_r;
  logic [3:0]  err_r;
  logic        byte_done;
  logic        commit;
  logic        wsec_r;
  logic        rsec_r;
  logic [1:0]  full_r;

  assign sample    = ctrl_r[vbi_slicer_pkg::CTRL_SRC_BIT] ? video_b : video_a;
  assign level_sum = {1'b0, vmin_r} + {1'b0, vmax_r};
  assign bit_now   = sample > level_sum[8:1];
  assign phase_sum = {1'b0, phase_r} + {1'b0, inc_r};
  assign strobe    = phase_sum[32];
  assign sh_nxt    = {sh_r[22:0], bit_now};
  assign byte_nxt  = {bit_now, byte_r[7:1]};
  assign byte_done = state_r == vbi_slicer_pkg::S_DATA && strobe &&
                     bitc_r == 3'd7;
  assign commit    = state_r == vbi_slicer_pkg::S_DONE &&
                     err_r <= ctrl_r[vbi_slicer_pkg::CTRL_ERR_LSB +: 4];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= vbi_slicer_pkg::S_IDLE;
    end else if (horizontal_reference_fall) begin
      state_r <= vbi_slicer_pkg::S_IDLE;
    end else begin
      case (state_r)
        vbi_slicer_pkg::S_IDLE: begin
          if (hcnt_r == horiz_trigger_offset && en_nxt &&
              !full_r[wsec_r]) begin
            state_r <= vbi_slicer_pkg::S_RUNIN;
          end
        end
        vbi_slicer_pkg::S_RUNIN: begin
          if (bit_now && !bit_d_r &&
              edge_cnt_r == 2'(vbi_slicer_pkg::RUNIN_EDGES - 1)) begin
            state_r <= vbi_slicer_pkg::S_FRAME;
          end
        end
        vbi_slicer_pkg::S_FRAME: begin
          if (strobe && (sh_nxt & fc_mask_r) == fc_r) begin
            state_r <= vbi_slicer_pkg::S_DATA;
          end else if (strobe && !open_r &&
                       fbits_r == 6'(vbi_slicer_pkg::FC_WINDOW_BITS - 1)) begin
            state_r <= vbi_slicer_pkg::S_IDLE;
          end
        end
        vbi_slicer_pkg::S_DATA: begin
          if (byte_done && bytes_r == nbytes_r - 6'd1) begin
            state_r <= vbi_slicer_pkg::S_DONE;
          end
        end
        default: state_r <= vbi_slicer_pkg::S_IDLE;
      endcase
    end
  end

  // Per-line setup, threshold and phase recovery
  always_ff @(posedge clk) begin
    if (!rstn) begin
      inc_r      <= 32'h0000_0000;
      fc_r       <= 24'h00_0000;
      fc_mask_r  <= 24'h00_0000;
      nbytes_r   <= 6'd0;
      ham_r      <= 1'b0;
      open_r     <= 1'b0;
      vmin_r     <= 8'hFF;
      vmax_r     <= 8'h00;
      phase_r    <= 32'h0000_0000;
      edge_cnt_r <= 2'd0;
      bit_d_r    <= 1'b0;
    end else begin
      bit_d_r <= bit_now;
      phase_r <= phase_sum[31:0];
      if (state_r == vbi_slicer_pkg::S_IDLE) begin
        inc_r      <= inc_nxt;
        fc_r       <= fc_nxt;
        fc_mask_r  <= 24'((25'h1 << fc_len_nxt) - 25'h1);
        nbytes_r   <= nbytes_nxt;
        ham_r      <= ham_nxt;
        open_r     <= open_nxt;
        vmin_r     <= 8'hFF;
        vmax_r     <= 8'h00;
        edge_cnt_r <= 2'd0;
      end else if (state_r == vbi_slicer_pkg::S_RUNIN) begin
        if (sample < vmin_r) begin
          vmin_r <= sample;
        end
        if (sample > vmax_r) begin
          vmax_r <= sample;
        end
        if (bit_now && !bit_d_r) begin
          phase_r    <= 32'h8000_0000;
          edge_cnt_r <= edge_cnt_r + 2'd1;
        end
      end
    end
  end

  // Framing search and byte assembly
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_r    <= 24'h00_0000;
      fbits_r <= 6'd0;
      bitc_r  <= 3'd0;
      byte_r  <= 8'h00;
      bytes_r <= 6'd0;
      err_r   <= 4'h0;
    end else if (state_r == vbi_slicer_pkg::S_IDLE ||
                 state_r == vbi_slicer_pkg::S_RUNIN) begin
      sh_r    <= 24'h00_0000;
      fbits_r <= 6'd0;
      bitc_r  <= 3'd0;
      bytes_r <= 6'd0;
      err_r   <= 4'h0;
    end else if (strobe && state_r == vbi_slicer_pkg::S_FRAME) begin
      sh_r    <= sh_nxt;
      fbits_r <= fbits_r + 6'd1;
    end else if (strobe && state_r == vbi_slicer_pkg::S_DATA) begin
      bitc_r <= bitc_r + 3'd1;
      byte_r <= byte_nxt;
      if (byte_done) begin
        bytes_r <= bytes_r + 6'd1;
        if (ham_r && !(^byte_nxt) && err_r != 4'hF) begin
          err_r <= err_r + 4'h1;
        end
      end
    end
  end

  // Text FIFO storage, two sections
  logic [31:0] mem_r [vbi_slicer_pkg::NUM_SECT * SW];
  logic [3:0]  words_r [vbi_slicer_pkg::NUM_SECT];
  logic [4:0]  wr_addr;
  logic [4:0]  rd_addr;
  logic [3:0]  ridx_r;
  logic        rd_push;
  logic        rd_last;
  logic        buf_ready;
  logic [32:0] buf_out;

  assign wr_addr = 5'(wsec_r ? SW : 0) + 5'(bytes_r[5:2]);
  assign rd_addr = 5'(rsec_r ? SW : 0) + 5'(ridx_r);
  assign rd_last = ridx_r == words_r[rsec_r] - 4'd1;
  assign rd_push = full_r[rsec_r] && buf_ready;

  always_ff @(posedge clk) begin
    if (byte_done) begin
      if (bytes_r[1:0] == 2'd0) begin
        mem_r[wr_addr] <= {24'h00_0000, byte_nxt};
      end else begin
        mem_r[wr_addr][8 * bytes_r[1:0] +: 8] <= byte_nxt;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      full_r     <= 2'b00;
      wsec_r     <= 1'b0;
      rsec_r     <= 1'b0;
      ridx_r     <= 4'd0;
      words_r[0] <= 4'd0;
      words_r[1] <= 4'd0;
    end else begin
      if (commit) begin
        full_r[wsec_r]  <= 1'b1;
        words_r[wsec_r] <= 4'((bytes_r + 6'd3) >> 2);
        wsec_r          <= !wsec_r;
      end
      if (rd_push) begin
        ridx_r <= ridx_r + 4'd1;
        if (rd_last) begin
          full_r[rsec_r] <= 1'b0;
          rsec_r         <= !rsec_r;
          ridx_r         <= 4'd0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_ready <= 1'b0;
    end else begin
      line_ready <= |full_r;
    end
  end

  vbi_skid_buf #(
    .W(33)
  ) u_buf (
    .clk      (clk),
    .rstn     (rstn),
    .in_data  ({rd_last, mem_r[rd_addr]}),
    .in_valid (full_r[rsec_r]),
    .in_ready (buf_ready),
    .out_data (buf_out),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  assign out_data = buf_out[31:0];
  assign out_last = buf_out[32];

endmodule : vbi_data_slicer

//--- vbi_slicer_pkg.sv
package vbi_slicer_pkg;

  // Register subaddresses
  localparam logic [7:0] ADDR_CTRL       = 8'h40;
  localparam logic [7:0] ADDR_LINE_FIRST = 8'h41;
  localparam logic [7:0] ADDR_LINE_LAST  = 8'h57;
  localparam logic [7:0] ADDR_HORIZ_TRIGGER_OFFSET_LO    = 8'h59;
  localparam logic [7:0] ADDR_VERT_TRIGGER_OFFSET_LO    = 8'h5A;
  localparam logic [7:0] ADDR_OFF_HI     = 8'h5B;
  localparam logic [7:0] ADDR_FC_PROG    = 8'h5C;
  localparam logic [7:0] ADDR_TYPE       = 8'h62;

  // Values after reset
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_LINE = 8'hFF;
  localparam logic [7:0] RST_OFF  = 8'h00;
  localparam logic [7:0] RST_FC   = 8'h00;
  localparam logic [7:0] RST_TYPE = 8'h0F;

  // Field positions
  localparam int CTRL_ERR_LSB  = 0;
  localparam int CTRL_SRC_BIT  = 6;
  localparam int HORIZ_TRIGGER_OFFSET_HI_LSB   = 0;
  localparam int VERT_TRIGGER_OFFSET_HI_BIT   = 4;
  localparam int FIELD_OFFSET_BIT_BIT      = 7;

  // Line range with own selections
  localparam int FIRST_LINE = 2;
  localparam int LAST_LINE  = 24;
  localparam int NUM_LINES  = LAST_LINE - FIRST_LINE + 1;

  // Text FIFO geometry
  localparam int SECT_BYTES = 56;
  localparam int SECT_WORDS = 14;
  localparam int NUM_SECT   = 2;

  // Slicer counts
  localparam int RUNIN_EDGES    = 3;
  localparam int FC_WINDOW_BITS = 40;

  localparam longint unsigned CLK_HZ = 125000000;

  typedef enum logic [3:0] {
    T_WST625 = 4'h0, T_CC625  = 4'h1, T_VPS    = 4'h2, T_WSS    = 4'h3,
    T_WST525 = 4'h4, T_CC525  = 4'h5, T_VIDEO  = 4'h6, T_RAW    = 4'h7,
    T_TEXT   = 4'h8, T_VITC625 = 4'h9, T_VITC525 = 4'hA, T_RSVD = 4'hB,
    T_USTEXT = 4'hC, T_JAPTEXT = 4'hD, T_FSWITCH = 4'hE, T_NONE = 4'hF
  } slicer_type_code_type;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RUNIN = 3'b001,
    S_FRAME = 3'b011,
    S_DATA  = 3'b010,
    S_DONE  = 3'b110
  } slicer_state_type;

  function automatic logic [31:0] bit_inc(input longint unsigned rate);
    bit_inc = 32'((rate << 32) / CLK_HZ);
  endfunction : bit_inc

  localparam logic [31:0] INC_6937 = bit_inc(6937500);
  localparam logic [31:0] INC_5727 = bit_inc(5727200);
  localparam logic [31:0] INC_5000 = bit_inc(5000000);
  localparam logic [31:0] INC_0500 = bit_inc(500000);
  localparam logic [31:0] INC_0503 = bit_inc(503000);
  localparam logic [31:0] INC_1812 = bit_inc(1812500);
  localparam logic [31:0] INC_1789 = bit_inc(1789800);

  localparam logic [23:0] FC_TEXT = 24'h000027;
  localparam logic [23:0] FC_CC   = 24'h000001;
  localparam logic [23:0] FC_VPS  = 24'h009951;
  localparam logic [23:0] FC_WSS  = 24'h1E3C1F;

endpackage : vbi_slicer_pkg

//--- vbi_skid_buf.sv
`timescale 1ns/1ps
module vbi_skid_buf #(
  parameter int W = 33
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0] d0_r;
  logic [W-1:0] d1_r;
  logic         v0_r;
  logic         v1_r;
  logic         push;
  logic         pop;

  assign in_ready  = !v1_r;
  assign push      = in_valid && !v1_r;
  assign pop       = v0_r && out_ready;
  assign out_data  = d0_r;
  assign out_valid = v0_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= '0;
      d1_r <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!v0_r) begin
            v0_r <= 1'b1;
            d0_r <= in_data;
          end else begin
            v1_r <= 1'b1;
            d1_r <= in_data;
          end
        end
        2'b01: begin
          v0_r <= v1_r;
          d0_r <= d1_r;
          v1_r <= 1'b0;
        end
        2'b11: begin
          if (v1_r) begin
            d0_r <= d1_r;
            d1_r <= in_data;
          end else begin
            d0_r <= in_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule : vbi_skid_buf

//--- vbi_slicer_checker.sv
`timescale 1ns/1ps
module vbi_slicer_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_we,
  input wire logic [7:0]  reg_rdata,
  input wire logic [31:0] out_data,
  input wire logic        out_last,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        line_ready
);
  default clocking cb @(posedge clk); endclocking
  sequence s_wr;
    reg_we && reg_addr inside {[8'h41:8'h57]};
  endsequence
  sequence s_keep;
    !reg_we && reg_addr == $past(reg_addr);
  endsequence
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  property p_rst_out;
    !rstn |=> !out_valid && !line_ready && reg_rdata == 8'h00;
  endproperty
  property p_rst_type;
    !rstn ##1 (rstn && !reg_we && reg_addr == 8'h62)
      |=> reg_rdata == vbi_slicer_pkg::RST_TYPE;
  endproperty
  property p_rd_gap;
    disable iff (!rstn)
    reg_addr inside {8'h58, [8'h5D:8'h61]} |=> reg_rdata == 8'h00;
  endproperty
  property p_rd_out;
    disable iff (!rstn)
    reg_addr < 8'h40 || reg_addr > 8'h62 |=> reg_rdata == 8'h00;
  endproperty
  property p_wr_rd;
    disable iff (!rstn)
    s_wr ##1 s_keep |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_hold_v;
    disable iff (!rstn) s_stall |=> out_valid;
  endproperty
  property p_hold_d;
    disable iff (!rstn)
    s_stall |=> $stable(out_data) && $stable(out_last);
  endproperty
  property p_lr_v;
    disable iff (!rstn) $rose(line_ready) |-> ##[0:2] out_valid;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not cleared in reset");
  a_rst_type: assert property (p_rst_type)
    else $error("type select reset value wrong");
  a_rd_gap: assert property (p_rd_gap)
    else $error("gap address reads nonzero");
  a_rd_out: assert property (p_rd_out)
    else $error("outside address reads nonzero");
  a_wr_rd: assert property (p_wr_rd)
    else $error("line select readback wrong");
  a_hold_v: assert property (p_hold_v)
    else $error("valid dropped in stall");
  a_hold_d: assert property (p_hold_d)
    else $error("word changed in stall");
  a_lr_v: assert property (p_lr_v)
    else $error("ready line not offered");
endmodule : vbi_slicer_checker

bind vbi_data_slicer vbi_slicer_checker u_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_rdata(reg_rdata), .out_data(out_data),
  .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready),
  .line_ready(line_ready));

//--- vbi_video_src.sv
`timescale 1ns/1ps
module vbi_video_src (
  input  wire logic clk,
  input  wire logic stall,
  output logic      horizontal_reference,
  output logic      vertical_reference,
  output logic [7:0] video_a,
  output logic      out_ready
);
  localparam int BIT_CLKS = 25;
  initial begin
    horizontal_reference = 1'b1;
    vertical_reference = 1'b1;
    video_a = 8'h10;
    out_ready = 1'b0;
  end
  always @(posedge clk) #1 out_ready = !stall && ($urandom_range(3) != 0);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic field_start;
    tick(1);
    vertical_reference = 1'b0;
    tick(10);
    vertical_reference = 1'b1;
  endtask : field_start
  // Run-in, framing byte, two data bytes, all LSB first
  task automatic send_line(input logic [7:0] fc, input logic [15:0] d);
    logic [31:0] bits;
    bits = {d, fc, 8'h55};
    tick(1);
    horizontal_reference = 1'b0;
    tick(100);
    for (int i = 0; i < 32; i++) begin
      video_a = bits[i] ? 8'hC8 : 8'h10;
      tick(BIT_CLKS);
    end
    video_a = 8'h10;
    tick(380);
    horizontal_reference = 1'b1;
    tick(20);
  endtask : send_line
endmodule : vbi_video_src

//--- tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = vbi_slicer_pkg::ADDR_TYPE;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_we = 1'b0;
  logic        stall = 1'b0;
  logic        fid = 1'b0;
  logic [7:0]  reg_rdata;
  logic [31:0] out_data;
  logic        out_last;
  logic        out_valid;
  logic        out_ready;
  logic        line_ready;
  logic        horizontal_reference;
  logic        vertical_reference;
  logic [7:0]  video_a;
  logic [15:0] dat;
  logic [31:0] exp_q[$];
  logic [7:0]  ra[7] = '{8'h62, 8'h41, 8'h57, 8'h59, 8'h5C, 8'h58, 8'hFF};
  logic [7:0]  re[7] = '{8'h0F, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          taken = 0;
  int          seed;
  vbi_data_slicer dut (.clk(clk), .rstn(rstn), .video_a(video_a),
    .video_b(8'h80), .horizontal_reference(horizontal_reference),
    .vertical_reference(vertical_reference), .field_id(fid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .out_data(out_data), .out_last(out_last),
    .out_valid(out_valid), .out_ready(out_ready),
    .line_ready(line_ready));
  vbi_video_src src (.clk(clk), .stall(stall),
    .horizontal_reference(horizontal_reference),
    .vertical_reference(vertical_reference), .video_a(video_a),
    .out_ready(out_ready));
  always #4 clk = ~clk;
  function automatic logic [31:0] exp_word(input logic [15:0] d);
    exp_word = {16'h0000, d};
  endfunction : exp_word
  task automatic results;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic cmp8(input string s, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : cmp8
  task automatic cmp32(input string s, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : cmp32
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    tick(1);
    reg_we = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    tick(1);
    cmp8("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic lines(input int n, input logic [7:0] fc, input bit keep);
    repeat (n) begin
      // Dropped lines carry zeros so no stray framing match
      dat = keep ? 16'($urandom()) : 16'h0000;
      if (keep)
        exp_q.push_back(exp_word(dat));
      src.send_line(fc, dat);
    end
  endtask : lines
  always @(negedge clk) begin
    if (rstn && out_valid === 1'b1 && out_ready === 1'b1) begin
      taken++;
      if (exp_q.size() == 0) exp_q.push_back(32'h0000_0000);
      cmp32("out_data", exp_q.pop_front(), out_data);
      cmp8("out_last", 8'h01, {7'h00, out_last});
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    seed = $urandom(71);
    tick(2);
    rstn = 1'b1;
    foreach (ra[i]) rd(ra[i], re[i]);
    cmp8("line_ready", 8'h00, {7'h00, line_ready});
    for (int a = 8'h41; a <= 8'h57; a++) begin
      dat = 16'($urandom());
      wr(8'(a), dat[7:0]);
      rd(8'(a), dat[7:0]);
    end
    wr(8'h58, 8'hA5);
    rd(8'h58, 8'h00);
    $display("test registers done");
    wr(vbi_slicer_pkg::ADDR_CTRL, 8'h00);
    wr(vbi_slicer_pkg::ADDR_FC_PROG, 8'h66);
    wr(vbi_slicer_pkg::ADDR_TYPE, 8'h0E);
    for (int a = 8'h41; a <= 8'h57; a++) wr(8'(a), 8'hEE);
    src.field_start();
    lines(4, 8'h66, 1'b1);
    tick(60);
    cmp8("queue", 8'h00, 8'(exp_q.size()));
    $display("test slicing done");
    stall = 1'b1;
    lines(3, 8'h66, 1'b1);
    cmp8("line_ready", 8'h01, {7'h00, line_ready});
    cmp8("out_valid", 8'h01, {7'h00, out_valid});
    stall = 1'b0;
    tick(100);
    cmp8("queue", 8'h00, 8'(exp_q.size()));
    $display("test stall done");
    seed = taken;
    wr(vbi_slicer_pkg::ADDR_OFF_HI, 8'h07);
    wr(vbi_slicer_pkg::ADDR_HORIZ_TRIGGER_OFFSET_LO, 8'hFF);
    lines(1, 8'h66, 1'b0);
    wr(vbi_slicer_pkg::ADDR_OFF_HI, 8'h00);
    wr(vbi_slicer_pkg::ADDR_HORIZ_TRIGGER_OFFSET_LO, 8'h00);
    lines(1, 8'h99, 1'b0);
    wr(vbi_slicer_pkg::ADDR_TYPE, 8'h0F);
    for (int a = 8'h41; a <= 8'h57; a++) wr(8'(a), 8'hFE);
    fid = 1'b1;
    lines(1, 8'h66, 1'b0);
    tick(60);
    cmp8("taken", 8'(seed), 8'(taken));
    $display("test no output done");
    results();
  end
endmodule : tb
